/* bench/pia_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Core side: takes vector calls, issues traps
// ----
module pia_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic vector_call_instruction,
	input wire logic [15:0] vector_location,
	input wire logic [2:0] ack_line,
	output logic trap_exec,
	output int n_ack,
	output logic [15:0] last_vec,
	output logic [2:0] last_line
);
	initial trap_exec = 1'b0;
	// Latch the location as the core loads its counter on each call
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n_ack <= 0;
		end else if (vector_call_instruction) begin
			n_ack <= n_ack + 1;
			last_vec <= vector_location;
			last_line <= ack_line;
		end
	end
	// One-cycle pulse, same clock, no sync needed
	task fire_trap();
		@(posedge pclk);
		trap_exec <= 1'b1;
		@(posedge pclk);
		trap_exec <= 1'b0;
	endtask
endmodule // pia_core_model
`default_nettype wire

/* bench/pia_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// Acknowledge checker
// ----
module pia_monitor #(
	parameter ADDR_W = 17
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic trap_exec,
	input wire logic vector_call_instruction,
	input wire logic [15:0] vector_location,
	input wire logic [2:0] ack_line,
	input wire logic global_mask_bit
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_line_ack;
		vector_call_instruction && ack_line >= 3'd2;
	endsequence
	sequence s_trap_done;
		vector_call_instruction && vector_location == 16'h0022;
	endsequence
	a_reset_mask: assert property ($rose(presetn) |-> global_mask_bit)
		else $error("mask clear after reset");
	a_ack_mask: assert property (vector_call_instruction && vector_location != 16'h0022 |-> global_mask_bit)
		else $error("mask clear after ack");
	a_trap_mask: assert property (s_trap_done |-> global_mask_bit == $past(global_mask_bit))
		else $error("trap changed mask");
	a_trap_call: assert property (trap_exec |-> ##[1:3] s_trap_done)
		else $error("trap not vectored");
	a_line_gated: assert property (s_line_ack |-> !$past(global_mask_bit))
		else $error("line acked while masked");
	a_line_vector: assert property (s_line_ack |-> vector_location == {12'h000, ack_line - 3'd1, 1'b0})
		else $error("wrong line vector");
	a_nmi_vector: assert property (vector_call_instruction && ack_line == 3'd1 |-> vector_location == 16'h0024)
		else $error("wrong nmi vector");
	a_loc_held: assert property (!vector_call_instruction |-> $stable(vector_location))
		else $error("vector moved without call");
	a_mask_read: assert property (psel && penable && pready && !pwrite && paddr == 17'h1C000 |-> prdata[9] == $past(global_mask_bit))
		else $error("status bit differs");
	a_setup_ready: assert property (s_setup |=> pready)
		else $error("no ready after setup");
endmodule // pia_monitor

bind pia_top pia_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .trap_exec(trap_exec),
	.vector_call_instruction(vector_call_instruction), .vector_location(vector_location), .ack_line(ack_line),
	.global_mask_bit(global_mask_bit));
`default_nettype wire

/* bench/prioritized_interrupt_arbiter_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module prioritized_interrupt_arbiter_tb;
	logic pclk, presetn, psel, penable, pwrite, rerr, nmi, emu;
	logic [16:0] paddr;
	logic [31:0] pwdata, rdata;
	logic [17:0] src;
	logic [3:0] cl;
	wire [31:0] prdata;
	wire pready, pslverr, vci, trap, gmask;
	wire [15:0] vloc;
	wire [2:0] aline;
	int num_errors, n_compared, acks;
	// ----
	// Rows: register index above, expected offset below, in priority order
	// ----
	logic [31:0] rows [20] = '{32'h701E_0001, 32'h701E_0011, 32'h701E_001F, 32'h701E_0005, 32'h701E_0006,
		32'h701E_0007, 32'h701E_0010, 32'h701E_0000, 32'h7432_0020, 32'h7432_0021, 32'h7432_0022,
		32'h7432_0023, 32'h7432_0024, 32'h7432_0025, 32'h7432_0026, 32'h7432_0027, 32'h7432_0028,
		32'h7432_0029, 32'h7432_002A, 32'h7432_0000};
	pia_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_irq_a(src[0]), .ext_irq_b(src[1]),
		.ext_irq_c(src[2]), .serial_peripheral_irq(src[3]), .async_receive_irq(src[4]), .async_transmit_irq(src[5]),
		.realtime_tick_irq(src[6]), .drive_protect_irq(src[7]), .full_compare_one_irq(src[8]),
		.full_compare_two_irq(src[9]), .full_compare_three_irq(src[10]), .simple_compare_one_irq(src[11]),
		.simple_compare_two_irq(src[12]), .simple_compare_three_irq(src[13]), .timer_one_period_irq(src[14]),
		.timer_one_compare_irq(src[15]), .timer_one_underflow_irq(src[16]), .timer_one_overflow_irq(src[17]),
		.core_line_three(cl[0]), .core_line_four(cl[1]), .core_line_five(cl[2]), .core_line_six(cl[3]),
		.nmi_req(nmi), .emulator_trap_line(emu), .trap_exec(trap), .vector_call_instruction(vci),
		.vector_location(vloc), .ack_line(aline), .global_mask_bit(gmask));
	pia_core_model core (.pclk(pclk), .presetn(presetn), .vector_call_instruction(vci), .vector_location(vloc),
		.ack_line(aline), .trap_exec(trap), .n_ack(), .last_vec(), .last_line());
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx[14:0], 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("CHECK FAILED t=%0t no bus answer", $time);
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task ack_chk(input logic [15:0] v, input logic [2:0] l);
		int n;
		n = 0;
		while (core.n_ack <= acks && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (core.n_ack <= acks) begin
			num_errors++;
			$display("CHECK FAILED t=%0t no vector call", $time);
		end
		acks++;
		`CHK(core.last_vec, v)
		`CHK(core.last_line, l)
	endtask
	task grant(input logic [15:0] v, input logic [2:0] l);
		apb(1'b1, `PIA_IDX_STATUS, 32'h0);
		ack_chk(v, l);
	endtask
	task summarize();
		$display("compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge pclk);
		num_errors++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		summarize();
	end
	initial begin
		{psel, penable, pwrite, nmi, emu} = 5'h00;
		{paddr, pwdata, src, cl} = '0;
		{num_errors, n_compared, acks} = '0;
		presetn = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		`CHK(gmask, 1'b1)
		apb(1'b0, `PIA_IDX_STATUS, 32'h0);
		`CHK(rdata[9], 1'b1)
		apb(1'b0, `PIA_IDX_LMASK, 32'h0);
		`CHK(rdata[5:0], 6'h00)
		apb(1'b0, 16'h7FFF, 32'h0);
		`CHK(rerr, 1'b1)
		$display("reset test done");
		src <= '1;
		repeat (6) @(posedge pclk);
		src <= '0;
		repeat (4) @(posedge pclk);
		apb(1'b0, `PIA_IDX_L1FLAG, 32'h0);
		`CHK(rdata[6:0], 7'h7F)
		apb(1'b0, `PIA_IDX_L2FLAG, 32'h0);
		`CHK(rdata[10:0], 11'h7FF)
		apb(1'b0, `PIA_IDX_PEND, 32'h0);
		`CHK(rdata[7:0], 8'h00)
		apb(1'b1, `PIA_IDX_L1EN, 32'h7F);
		apb(1'b1, `PIA_IDX_L2EN, 32'h7FF);
		repeat (4) @(posedge pclk);
		apb(1'b0, `PIA_IDX_PEND, 32'h0);
		`CHK(rdata[7:0], 8'h0C)
		$display("flag test done");
		apb(1'b1, `PIA_IDX_LMASK, 32'h02);
		grant(16'h0004, 3'd3);
		apb(1'b0, `PIA_IDX_PEND, 32'h0);
		`CHK(rdata[7:0], 8'h04)
		cl <= 4'b0101;
		repeat (6) @(posedge pclk);
		cl <= 4'b0000;
		apb(1'b1, `PIA_IDX_LMASK, 32'h3F);
		grant(16'h0002, 3'd2);
		grant(16'h0006, 3'd4);
		grant(16'h000A, 3'd6);
		`CHK(gmask, 1'b1)
		nmi <= 1'b1;
		emu <= 1'b1;
		ack_chk(16'h0026, 3'd0);
		ack_chk(16'h0024, 3'd1);
		nmi <= 1'b0;
		emu <= 1'b0;
		apb(1'b1, `PIA_IDX_STATUS, 32'h0);
		core.fire_trap();
		ack_chk(16'h0022, 3'd0);
		`CHK(gmask, 1'b0)
		$display("acknowledge test done");
		foreach (rows[i]) begin
			apb(1'b0, rows[i][31:16], 32'h0);
			`CHK(rdata[15:0], rows[i][15:0])
		end
		apb(1'b0, `PIA_IDX_L1FLAG, 32'h0);
		`CHK(rdata[6:0], 7'h00)
		$display("vector test done");
		summarize();
	end
endmodule // prioritized_interrupt_arbiter_tb
`default_nettype wire

/* hw/pia_core_sel.v */
`timescale 1ns/1ps
`default_nettype none

module pia_core_sel (
	input wire [7:0] pend,
	input wire [5:0] line_mask,
	input wire global_mask,
	output reg grant,
	output reg [2:0] sel
);
	reg [7:0] elig;
	integer i;

	// ----------------------------------------
	// Rank order: emulator trap, nmi, lines one..six
	// ----------------------------------------
	always @* begin
		elig = {pend[7:2] & line_mask & {6{~global_mask}}, pend[1:0]}; // [RQ8] [RQ10] [RQ11]
		grant = 1'b0;
		sel = 3'h0;
		for (i = 7; i >= 0; i = i - 1) begin
			if (elig[i]) begin // [RQ1] [RQ2]
				grant = 1'b1;
				sel = i[2:0];
			end
		end
	end
endmodule // pia_core_sel

`default_nettype wire

/* hw/pia_defines.vh */
`ifndef PIA_DEFINES_VH
`define PIA_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PIA_IDX_STATUS 16'h7000
`define PIA_IDX_LMASK 16'h7004
`define PIA_IDX_PEND 16'h7006
`define PIA_IDX_L1FLAG 16'h7010
`define PIA_IDX_L1EN 16'h7012
`define PIA_IDX_SYSVEC 16'h701E
`define PIA_IDX_L2FLAG 16'h7430
`define PIA_IDX_L2EN 16'h7431
`define PIA_IDX_EVAVEC 16'h7432

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PIA_GMASK_BIT 9
`define PIA_GMASK_RST 1'b1
`define PIA_LMASK_RST 6'h00
`define PIA_PHANTOM 16'h0000

// ----------------------------------------
// Source offsets, index 0 is highest priority
// ----------------------------------------
`define PIA_L1_OFFS {16'h0010, 16'h0007, 16'h0006, 16'h0005, 16'h001F, 16'h0011, 16'h0001}
`define PIA_L2_OFFS {16'h002A, 16'h0029, 16'h0028, 16'h0027, 16'h0026, 16'h0025, 16'h0024, \
	16'h0023, 16'h0022, 16'h0021, 16'h0020}

// ----------------------------------------
// Core vector locations, pending bit order: emu, nmi, lines 1..6
// ----------------------------------------
`define PIA_VEC_TABLE {16'h000C, 16'h000A, 16'h0008, 16'h0006, 16'h0004, 16'h0002, 16'h0024, 16'h0026}
`define PIA_VEC_TRAP 16'h0022

`endif

/* hw/pia_line_arb.v */
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"

module pia_line_arb #(
	parameter N = 7,
	parameter [16*N-1:0] OFFS = {16*N{1'b0}}
) (
	input wire [N-1:0] req,
	output reg valid,
	output reg [4:0] index,
	output reg [15:0] offset
);
	integer i;

	// ----------------------------------------
	// Lowest index wins
	// ----------------------------------------
	always @* begin
		valid = 1'b0;
		index = 5'h00;
		offset = `PIA_PHANTOM;
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin // [RQ4] [RQ6]
				valid = 1'b1;
				index = i[4:0];
				offset = OFFS[16*i +: 16];
			end
		end
	end
endmodule // pia_line_arb

`default_nettype wire

/* hw/pia_top.v */
// How it works
// RQ1 - Core lines ranked 1 to 10; highest pending rank acknowledged first.
// RQ2 - Nonmaskable line rank 3, then lines one to six at ranks 4 to 9.
// RQ3 - Lines one, five, six and nonmaskable from system; two to four from events.
// RQ4 - Each maskable line gathers sources in fixed order; highest presented first.
// RQ5 - Each source has flag and enable; request sets flag regardless of enable.
// RQ6 - Only flagged and enabled sources arbitrate; the highest is forwarded.
// RQ7 - Forwarding a request on a line sets its pending-flag bit; the code sets it only when the line's request rises from none.
// RQ8 - Global mask bit 9 of status word zero: 0 permits, 1 blocks maskables.
// RQ9 - Global mask set at reset and on acknowledge except trap; software writes it.
// RQ10 - Each maskable line has a line-mask bit; unmasked only while it is 1.
// RQ11 - Maskable acknowledge needs top priority, global mask 0, line-mask bit 1.
// RQ12 - Acknowledge issues the vector call with the line's vector location.
// RQ13 - Vector-offset read returns source offset, or phantom 0000h if none.
// RQ14 - Line one pins a, b, c at 0001h, 0011h, 001Fh; register 701Eh, vector 0002h.
// RQ15 - Group A: drive-protect 0020h first through timer overflow 002Ah, register 7432h.
// RQ16 - Simple compares one to three report 0024h, 0025h, 0026h.
// RQ17 - Line one also carries serial, receive, transmit, tick at 0005h to 0010h.
// RQ18 - Trap vectors to 22h and leaves the global mask unchanged.
// RQ19 - Pending bit clears on acknowledge; source flag holds until serviced or cleared.
`timescale 1ns/1ps
`default_nettype none
`include "pia_defines.vh"

module pia_top #(
	parameter ADDR_W = 17
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_W-1:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire ext_irq_a,
	input wire ext_irq_b,
	input wire ext_irq_c,
	input wire serial_peripheral_irq,
	input wire async_receive_irq,
	input wire async_transmit_irq,
	input wire realtime_tick_irq,
	input wire drive_protect_irq,
	input wire full_compare_one_irq,
	input wire full_compare_two_irq,
	input wire full_compare_three_irq,
	input wire simple_compare_one_irq,
	input wire simple_compare_two_irq,
	input wire simple_compare_three_irq,
	input wire timer_one_period_irq,
	input wire timer_one_compare_irq,
	input wire timer_one_underflow_irq,
	input wire timer_one_overflow_irq,
	input wire core_line_three,
	input wire core_line_four,
	input wire core_line_five,
	input wire core_line_six,
	input wire nmi_req,
	input wire emulator_trap_line,
	input wire trap_exec,
	output reg vector_call_instruction,
	output reg [15:0] vector_location,
	output reg [2:0] ack_line,
	output reg global_mask_bit
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam NSYNC = 24;
	wire [NSYNC-1:0] raw_in;
	reg [NSYNC-1:0] sync1_reg;
	reg [NSYNC-1:0] sync2_reg;
	reg [7:0] hw_d_reg;

	assign raw_in = {emulator_trap_line, nmi_req, core_line_six, core_line_five, core_line_four,
		core_line_three, timer_one_overflow_irq, timer_one_underflow_irq, timer_one_compare_irq,
		timer_one_period_irq, simple_compare_three_irq, simple_compare_two_irq,
		simple_compare_one_irq, full_compare_three_irq, full_compare_two_irq,
		full_compare_one_irq, drive_protect_irq, realtime_tick_irq, async_transmit_irq,
		async_receive_irq, serial_peripheral_irq, ext_irq_c, ext_irq_b, ext_irq_a};

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_reg <= {NSYNC{1'b0}};
			sync2_reg <= {NSYNC{1'b0}};
		end else begin
			sync1_reg <= raw_in;
			sync2_reg <= sync1_reg;
		end
	end

	wire [6:0] l1_src = sync2_reg[6:0];
	wire [10:0] l2_src = sync2_reg[17:7];
	wire [3:0] l3to6_src = sync2_reg[21:18];
	wire nmi_s = sync2_reg[22];
	wire emu_s = sync2_reg[23];

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	reg [6:0] l1_flag_reg;
	reg [6:0] l1_flag_next;
	reg [6:0] l1_en_reg;
	reg [10:0] l2_flag_reg;
	reg [10:0] l2_flag_next;
	reg [10:0] l2_en_reg;
	reg [5:0] lmask_reg;
	reg [7:0] pend_reg;
	reg [7:0] pend_next;
	reg gmask_next;
	reg trap_pend_reg;
	reg [15:0] rd_idx_reg;
	reg [4:0] svc_idx_reg;
	reg svc_valid_reg;

	wire l1_valid;
	wire [4:0] l1_index;
	wire [15:0] l1_offset;
	wire l2_valid;
	wire [4:0] l2_index;
	wire [15:0] l2_offset;
	wire grant;
	wire [2:0] sel;
	wire [127:0] vec_table = `PIA_VEC_TABLE;

	pia_line_arb #(.N(7), .OFFS(`PIA_L1_OFFS)) u_line_one ( // [RQ14] [RQ17]
		.req(l1_flag_reg & l1_en_reg),
		.valid(l1_valid),
		.index(l1_index),
		.offset(l1_offset)
	);

	pia_line_arb #(.N(11), .OFFS(`PIA_L2_OFFS)) u_line_two ( // [RQ15] [RQ16]
		.req(l2_flag_reg & l2_en_reg),
		.valid(l2_valid),
		.index(l2_index),
		.offset(l2_offset)
	);

	pia_core_sel u_core_sel (
		.pend(pend_reg),
		.line_mask(lmask_reg),
		.global_mask(global_mask_bit),
		.grant(grant),
		.sel(sel)
	);

	// Bit order: emu, nmi, lines one..six; lines three to six come straight from their modules
	wire [7:0] hw_req = {l3to6_src, l2_valid, l1_valid, nmi_s, emu_s}; // [RQ3]

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	// Byte address of a register index; index bits above the bus width are dropped on purpose
	function [ADDR_W-1:0] addr_of;
		input [15:0] idx;
		begin
			addr_of = {idx[ADDR_W-3:0], 2'b00};
		end
	endfunction

	wire [ADDR_W-1:0] a_status = addr_of(`PIA_IDX_STATUS);
	wire [ADDR_W-1:0] a_lmask = addr_of(`PIA_IDX_LMASK);
	wire [ADDR_W-1:0] a_pend = addr_of(`PIA_IDX_PEND);
	wire [ADDR_W-1:0] a_l1flag = addr_of(`PIA_IDX_L1FLAG);
	wire [ADDR_W-1:0] a_l1en = addr_of(`PIA_IDX_L1EN);
	wire [ADDR_W-1:0] a_sysvec = addr_of(`PIA_IDX_SYSVEC);
	wire [ADDR_W-1:0] a_l2flag = addr_of(`PIA_IDX_L2FLAG);
	wire [ADDR_W-1:0] a_l2en = addr_of(`PIA_IDX_L2EN);
	wire [ADDR_W-1:0] a_evavec = addr_of(`PIA_IDX_EVAVEC);

	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire wr = access & pwrite;
	wire rd_vec = access & ~pwrite & svc_valid_reg;
	wire hit_sysvec = (paddr == a_sysvec);
	wire hit_evavec = (paddr == a_evavec);
	reg [31:0] rdata;
	reg mapped;

	always @* begin
		mapped = 1'b1;
		rdata = 32'h00000000;
		case (paddr)
			a_status: rdata[`PIA_GMASK_BIT] = global_mask_bit;
			a_lmask: rdata[5:0] = lmask_reg;
			a_pend: rdata[7:0] = pend_reg;
			a_l1flag: rdata[6:0] = l1_flag_reg;
			a_l1en: rdata[6:0] = l1_en_reg;
			a_l2flag: rdata[10:0] = l2_flag_reg;
			a_l2en: rdata[10:0] = l2_en_reg;
			a_sysvec: rdata[15:0] = l1_offset; // [RQ13] [RQ14]
			a_evavec: rdata[15:0] = l2_offset; // [RQ13] [RQ15]
			default: mapped = 1'b0;
		endcase
	end

	// Data is captured in setup, so pready and prdata both come from flops with one wait-free access
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rd_idx_reg <= 16'h0000;
			svc_idx_reg <= 5'h00;
			svc_valid_reg <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			svc_valid_reg <= 1'b0;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rdata;
				rd_idx_reg <= {{(18-ADDR_W){1'b0}}, paddr[ADDR_W-1:2]};
				svc_valid_reg <= ~pwrite & ((hit_sysvec & l1_valid) | (hit_evavec & l2_valid));
				svc_idx_reg <= hit_sysvec ? l1_index : l2_index;
			end
		end
	end

	// ----------------------------------------
	// Source flags
	// ----------------------------------------
	// Clears from a write or a vector read lose to a request in the same cycle
	always @* begin
		l1_flag_next = l1_flag_reg;
		l2_flag_next = l2_flag_reg;
		if (wr && rd_idx_reg == `PIA_IDX_L1FLAG)
			l1_flag_next = l1_flag_next & ~pwdata[6:0];
		if (wr && rd_idx_reg == `PIA_IDX_L2FLAG)
			l2_flag_next = l2_flag_next & ~pwdata[10:0];
		if (rd_vec && rd_idx_reg == `PIA_IDX_SYSVEC)
			l1_flag_next[svc_idx_reg[2:0]] = 1'b0; // [RQ19]
		if (rd_vec && rd_idx_reg == `PIA_IDX_EVAVEC)
			l2_flag_next[svc_idx_reg[3:0]] = 1'b0; // [RQ19]
		l1_flag_next = l1_flag_next | l1_src; // [RQ5]
		l2_flag_next = l2_flag_next | l2_src; // [RQ5]
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			l1_flag_reg <= 7'h00;
			l2_flag_reg <= 11'h000;
			l1_en_reg <= 7'h00;
			l2_en_reg <= 11'h000;
			lmask_reg <= `PIA_LMASK_RST;
		end else begin
			l1_flag_reg <= l1_flag_next;
			l2_flag_reg <= l2_flag_next;
			if (wr && rd_idx_reg == `PIA_IDX_L1EN)
				l1_en_reg <= pwdata[6:0];
			if (wr && rd_idx_reg == `PIA_IDX_L2EN)
				l2_en_reg <= pwdata[10:0];
			if (wr && rd_idx_reg == `PIA_IDX_LMASK)
				lmask_reg <= pwdata[5:0]; // [RQ10]
		end
	end

	// ----------------------------------------
	// Pending flags, global mask and acknowledge
	// ----------------------------------------
	wire [7:0] ack_clr = grant ? (8'h01 << sel) : 8'h00;
	wire [7:0] req_rise = hw_req & ~hw_d_reg;

	always @* begin
		pend_next = (pend_reg & ~ack_clr) | req_rise; // [RQ7] [RQ19]
		if (wr && rd_idx_reg == `PIA_IDX_PEND)
			pend_next = (pend_reg & ~pwdata[7:0] & ~ack_clr) | req_rise;
		gmask_next = global_mask_bit;
		if (wr && rd_idx_reg == `PIA_IDX_STATUS)
			gmask_next = pwdata[`PIA_GMASK_BIT]; // [RQ9]
		if (grant)
			gmask_next = 1'b1; // [RQ9]
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_d_reg <= 8'h00;
			pend_reg <= 8'h00;
			global_mask_bit <= `PIA_GMASK_RST; // [RQ9]
			trap_pend_reg <= 1'b0;
			vector_call_instruction <= 1'b0;
			vector_location <= 16'h0000;
			ack_line <= 3'h0;
		end else begin
			hw_d_reg <= hw_req;
			pend_reg <= pend_next;
			global_mask_bit <= gmask_next; // [RQ8]
			vector_call_instruction <= grant | trap_pend_reg | trap_exec; // [RQ12]
			if (grant) begin
				vector_location <= vec_table[16*sel +: 16]; // [RQ12] [RQ14]
				ack_line <= sel;
				trap_pend_reg <= trap_pend_reg | trap_exec;
			end else if (trap_pend_reg | trap_exec) begin
				// Trap waits behind hardware lines and never touches the mask
				vector_location <= `PIA_VEC_TRAP; // [RQ18]
				ack_line <= 3'h0;
				trap_pend_reg <= 1'b0;
			end
		end
	end
endmodule // pia_top

`default_nettype wire
